// ### logic/mpc_map.svh
`ifndef MPC_MAP_SVH
`define MPC_MAP_SVH
// How it works
// - present value wraps from 999999 back to zero
// - primary reset held blocks count pulses and clears present value to zero
// - primary reset ends an active one-shot output at once
// - with backup enabled, restored outputs come back except in instant mode; one-shot reruns full time
// - one-shot time settable from 0.01 s to 99.99 s
// - non-negative group accepts set values 0 to 999999 only outside dual; dual accepts -99999 to 999999
// - signed group accepts set values -99999 to 999999
// - both outputs switch together except two-stage and twin, where output b separate, and batch, where output a is the batch output
// - dual counter treats both count inputs as plain up inputs
// - count pulse must stay high for the minimum width of the speed
// - total accumulator keeps counting after present value is cleared
// - secondary reset clears total; reset operation on total view clears both
// - total spans -99999 to 999999 and wraps to zero at the top
// - batch counts completions upward; batch output latches until batch reset
// - batch count held zero during batch reset; zero batch set never asserts
// - batch count wraps to zero at 999999
// - lowering batch set below count asserts output; raising keeps it latched
// - batch configuration forces the fast counting speed
// - dual difference allowed only in some output modes; reports a minus b
// - a reset in dual mode blocks only its own input, counted as zero
// - dual inputs span 0 to 999999; overflow shows all F and halts counting
// - twin runs two up counters; reset operation clears only displayed one
// - dual sum mode reports a plus b

`define MPC_ADDR_CONFIG     4'h0
`define MPC_ADDR_SET_A      4'h1
`define MPC_ADDR_SET_B      4'h2
`define MPC_ADDR_BATCH_SET  4'h3
`define MPC_ADDR_PULSE_TIME 4'h4
`define MPC_ADDR_COMMAND    4'h5
`define MPC_ADDR_PV_A       4'h6
`define MPC_ADDR_PV_B       4'h7
`define MPC_ADDR_TOTAL      4'h8
`define MPC_ADDR_BATCH      4'h9
`define MPC_ADDR_DUAL       4'hA
`define MPC_ADDR_STATUS     4'hB

`define MPC_CFG_FUNC_LSB    0
`define MPC_CFG_OMODE_LSB   3
`define MPC_CFG_IMODE_LSB   5
`define MPC_CFG_FAST        7
`define MPC_CFG_SIGNED      8
`define MPC_CFG_SUB         9
`define MPC_CFG_BACKUP      10
`define MPC_CFG_VIEW_AUX    11
`define MPC_CFG_RESET       12'h000
`define MPC_CFG_MASK        12'hFFF

`define MPC_CMD_RESET_OP    0
`define MPC_CMD_RESTORE     1
`define MPC_CMD_RST_OUT_A   2
`define MPC_CMD_RST_OUT_B   3
`define MPC_CMD_RST_BATCH   4

`define MPC_VAL_MAX         24'h0F423F
`define MPC_VAL_MIN         24'hFE7961
`define MPC_VAL_ZERO        24'h000000
`define MPC_VAL_OVF         24'hFFFFFF
`define MPC_SET_RESET       24'h000000
`define MPC_PULSE_MIN       14'h0001
`define MPC_PULSE_MAX       14'h270F
`define MPC_PULSE_RESET     14'h0001

`define MPC_CLK_MHZ         20
`define MPC_WIDTH_SLOW_US   16700
`define MPC_WIDTH_FAST_US   100
`define MPC_PULSE_UNIT_US   10000
`define MPC_SLOW_CYC        (`MPC_WIDTH_SLOW_US * `MPC_CLK_MHZ)
`define MPC_FAST_CYC        (`MPC_WIDTH_FAST_US * `MPC_CLK_MHZ)
`define MPC_UNIT_CYC        (`MPC_PULSE_UNIT_US * `MPC_CLK_MHZ)
`endif

// ### logic/mpc_pkg.sv
package mpc_pkg;
  typedef enum logic [2:0] {
    mpc_fn_single    = 3'h0,
    mpc_fn_two_stage = 3'h1,
    mpc_fn_total     = 3'h2,
    mpc_fn_batch     = 3'h3,
    mpc_fn_dual      = 3'h4,
    mpc_fn_twin      = 3'h5
  } mpc_func_type;

  typedef enum logic [1:0] {
    mpc_om_hold    = 2'h0,
    mpc_om_instant = 2'h1,
    mpc_om_oneshot = 2'h2
  } mpc_out_type;

  typedef enum logic [1:0] {
    mpc_in_up     = 2'h0,
    mpc_in_down   = 2'h1,
    mpc_in_updown = 2'h2
  } mpc_in_type;
endpackage

// ### logic/mpc_input_cond.sv
`timescale 1ns/1ns
`default_nettype none
module mpc_input_cond #(
  parameter int CW = 19
) (
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic          pin,
  input  wire logic [CW-1:0] width,
  output logic               level,
  output logic               rise
);
  logic          sync_1;
  logic          sync_2;
  logic [CW-1:0] cnt;
  wire  [CW-1:0] cnt_inc    = CW'(cnt + 1'b1);
  wire  [CW-1:0] next_cnt   = !sync_2 ? '0 : (cnt == width) ? cnt : cnt_inc;
  // level only after the pin stayed high for the full width
  wire           next_level = sync_2 & (level | (cnt_inc >= width));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_1 <= 1'b0;
      sync_2 <= 1'b0;
      cnt    <= '0;
      level  <= 1'b0;
      rise   <= 1'b0;
    end else begin
      sync_1 <= pin;
      sync_2 <= sync_1;
      cnt    <= next_cnt;
      level  <= next_level;
      rise   <= next_level & ~level;
    end
  end
endmodule // mpc_input_cond
`default_nettype wire

// ### logic/mpc_oneshot.sv
`timescale 1ns/1ns
`default_nettype none
module mpc_oneshot #(
  parameter int UNIT_CYC = 200000,
  parameter int UW       = 14
) (
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic          start,
  input  wire logic          stop,
  input  wire logic [UW-1:0] units,
  output logic               active
);
  localparam int PW = $clog2(UNIT_CYC + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(UNIT_CYC - 1);

  logic [PW-1:0] pre;
  logic [UW-1:0] rem;
  wire           unit_end = active & (pre == PRE_LAST);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      active <= 1'b0;
      pre    <= '0;
      rem    <= '0;
    end else if (stop) begin
      active <= 1'b0;
      pre    <= '0;
    end else if (start) begin
      active <= 1'b1;
      pre    <= '0;
      rem    <= units;
    end else if (unit_end) begin
      pre    <= '0;
      rem    <= UW'(rem - 1'b1);
      active <= (rem != UW'(1));
    end else if (active) begin
      pre    <= PW'(pre + 1'b1);
    end
  end
endmodule // mpc_oneshot
`default_nettype wire

// ### logic/mpc_core.sv
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "mpc_map.svh"
module mpc_core #(
  parameter int SLOW_CYC = `MPC_SLOW_CYC,
  parameter int FAST_CYC = `MPC_FAST_CYC,
  parameter int UNIT_CYC = `MPC_UNIT_CYC
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        count_input_a,
  input  wire logic        count_input_b,
  input  wire logic        reset_input_a,
  input  wire logic        reset_input_b,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic             control_output_a,
  output logic             control_output_b
);
  localparam int CW = 19;

  // settings written by software
  logic [11:0] cfg;
  logic [23:0] set_a;
  logic [23:0] set_b;
  logic [23:0] batch_set;
  logic [13:0] pulse_time;

  // counting state
  logic [23:0] pv_a;
  logic [23:0] pv_b;
  logic [23:0] total;
  logic [23:0] batch;
  logic        batch_out;
  logic        ovf;
  logic [1:0]  reach_q;
  logic [1:0]  hold_q;
  logic [1:0]  inst_q;
  logic [1:0]  os_active;

  function automatic logic in_range(input logic [31:0] v, input logic neg_ok);
    logic ext_ok;
    logic hi_ok;
    logic lo_ok;
    ext_ok = (v[31:24] == {8{v[23]}});
    hi_ok  = $signed(v[23:0]) <= $signed(`MPC_VAL_MAX);
    lo_ok  = neg_ok ? ($signed(v[23:0]) >= $signed(`MPC_VAL_MIN)) : !v[23];
    return ext_ok & hi_ok & lo_ok;
  endfunction

  function automatic logic [23:0] step(input logic [23:0] v, input logic inc,
                                       input logic dec, input logic [23:0] lo);
    logic [23:0] r;
    r = v;
    if (inc) begin
      r = (v == `MPC_VAL_MAX) ? `MPC_VAL_ZERO : 24'(v + 1'b1);
    end else if (dec) begin
      r = (v == lo) ? v : 24'(v - 1'b1);
    end
    return r;
  endfunction

  // decoded configuration
  wire mpc_pkg::mpc_func_type fn    = mpc_pkg::mpc_func_type'(cfg[`MPC_CFG_FUNC_LSB +: 3]);
  wire mpc_pkg::mpc_out_type  omode = mpc_pkg::mpc_out_type'(cfg[`MPC_CFG_OMODE_LSB +: 2]);
  wire mpc_pkg::mpc_in_type   imode = mpc_pkg::mpc_in_type'(cfg[`MPC_CFG_IMODE_LSB +: 2]);
  wire is_two_stage = (fn == mpc_pkg::mpc_fn_two_stage);
  wire is_total     = (fn == mpc_pkg::mpc_fn_total);
  wire is_batch     = (fn == mpc_pkg::mpc_fn_batch);
  wire is_dual      = (fn == mpc_pkg::mpc_fn_dual);
  wire is_twin      = (fn == mpc_pkg::mpc_fn_twin);
  wire plain_up     = is_dual | is_twin;
  wire view_aux     = cfg[`MPC_CFG_VIEW_AUX];
  wire fast         = cfg[`MPC_CFG_FAST] | is_batch;
  wire neg_ok       = cfg[`MPC_CFG_SIGNED] & ~plain_up;
  wire backup_en    = cfg[`MPC_CFG_BACKUP];

  // input conditioning
  wire [CW-1:0] width = fast ? CW'(FAST_CYC) : CW'(SLOW_CYC);
  wire          ev_a;
  wire          ev_b;
  wire          rst_a;
  wire          rst_b;

  mpc_input_cond #(.CW(CW)) u_cond_count_a (
    .clk   (clk),
    .nrst  (nrst),
    .pin   (count_input_a),
    .width (width),
    .level (),
    .rise  (ev_a)
  );

  mpc_input_cond #(.CW(CW)) u_cond_count_b (
    .clk   (clk),
    .nrst  (nrst),
    .pin   (count_input_b),
    .width (width),
    .level (),
    .rise  (ev_b)
  );

  mpc_input_cond #(.CW(CW)) u_cond_reset_a (
    .clk   (clk),
    .nrst  (nrst),
    .pin   (reset_input_a),
    .width (CW'(1)),
    .level (rst_a),
    .rise  ()
  );

  mpc_input_cond #(.CW(CW)) u_cond_reset_b (
    .clk   (clk),
    .nrst  (nrst),
    .pin   (reset_input_b),
    .width (CW'(1)),
    .level (rst_b),
    .rise  ()
  );

  // register writes
  wire wr_cfg   = reg_wr & (reg_addr == `MPC_ADDR_CONFIG);
  wire wr_set_a = reg_wr & (reg_addr == `MPC_ADDR_SET_A);
  wire wr_set_b = reg_wr & (reg_addr == `MPC_ADDR_SET_B);
  wire wr_bset  = reg_wr & (reg_addr == `MPC_ADDR_BATCH_SET);
  wire wr_ptime = reg_wr & (reg_addr == `MPC_ADDR_PULSE_TIME);
  wire wr_cmd   = reg_wr & (reg_addr == `MPC_ADDR_COMMAND);
  wire set_neg  = cfg[`MPC_CFG_SIGNED] | is_dual;
  wire set_ok   = in_range(reg_wdata, set_neg);
  wire bset_ok  = in_range(reg_wdata, 1'b0);
  wire ptime_ok = (reg_wdata[31:14] == 18'h00000) &&
                  (reg_wdata[13:0] >= `MPC_PULSE_MIN) && (reg_wdata[13:0] <= `MPC_PULSE_MAX);
  wire op       = wr_cmd & reg_wdata[`MPC_CMD_RESET_OP];
  wire restore  = wr_cmd & reg_wdata[`MPC_CMD_RESTORE] & backup_en;
  wire [1:0] restore_out = {2{restore}} & reg_wdata[`MPC_CMD_RST_OUT_B:`MPC_CMD_RST_OUT_A];
  wire restore_batch     = restore & reg_wdata[`MPC_CMD_RST_BATCH];

  // clearing sources
  wire op_twin_b  = op & is_twin & view_aux;
  wire clr_pv_a   = rst_a | (op & ~op_twin_b);
  wire clr_pv_b   = (is_dual & (rst_b | op)) | (is_twin & (rst_b | op_twin_b));
  wire clr_total  = is_total & (rst_b | (op & view_aux));
  wire clr_batch  = is_batch & (rst_b | (op & view_aux));
  wire [1:0] clr_ch;
  assign clr_ch[0] = clr_pv_a;
  assign clr_ch[1] = is_twin ? clr_pv_b : clr_pv_a;

  // count events
  wire up_ev  = ev_a & (plain_up | (imode != mpc_pkg::mpc_in_down));
  wire dn_ev  = ~plain_up & ((imode == mpc_pkg::mpc_in_down) ? ev_a :
                             (imode == mpc_pkg::mpc_in_updown) ? ev_b : 1'b0);
  wire inc_a0 = up_ev & ~dn_ev & ~ovf;
  wire dec_a  = dn_ev & ~up_ev & ~ovf;
  wire inc_b0 = plain_up & ev_b & ~ovf;
  wire ovf_hit = is_dual & ((inc_a0 & (pv_a == `MPC_VAL_MAX)) |
                            (inc_b0 & (pv_b == `MPC_VAL_MAX)));
  wire inc_a  = inc_a0 & ~ovf_hit;
  wire inc_b  = inc_b0 & ~ovf_hit;
  wire [23:0] lo_a = neg_ok ? `MPC_VAL_MIN : `MPC_VAL_ZERO;

  // dual result, a reset input counts its side as zero
  wire [23:0] dual_a   = rst_a ? `MPC_VAL_ZERO : pv_a;
  wire [23:0] dual_b   = rst_b ? `MPC_VAL_ZERO : pv_b;
  wire        sub_ok   = (omode != mpc_pkg::mpc_om_oneshot);
  wire        sub      = cfg[`MPC_CFG_SUB] & sub_ok;
  wire [23:0] dual_val = ovf ? `MPC_VAL_OVF :
                         sub ? 24'(dual_a - dual_b) : 24'(dual_a + dual_b);
  wire [23:0] prim_val = is_dual ? dual_val : pv_a;

  // output channels
  wire [23:0] ch_val [2];
  wire [23:0] ch_set [2];
  assign ch_val[0] = prim_val;
  assign ch_set[0] = set_a;
  assign ch_val[1] = is_twin ? pv_b : prim_val;
  assign ch_set[1] = (is_two_stage | is_twin) ? set_b : set_a;

  wire [1:0] reach;
  wire [1:0] done;
  wire [1:0] ch_out;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      assign reach[gi] = (ch_val[gi] == ch_set[gi]) & ~ovf;
      assign done[gi]  = reach[gi] & ~reach_q[gi];

      mpc_oneshot #(.UNIT_CYC(UNIT_CYC), .UW(14)) u_oneshot (
        .clk    (clk),
        .nrst   (nrst),
        .start  ((done[gi] | restore_out[gi]) & (omode == mpc_pkg::mpc_om_oneshot)),
        .stop   (clr_ch[gi]),
        .units  (pulse_time),
        .active (os_active[gi])
      );

      assign ch_out[gi] = (omode == mpc_pkg::mpc_om_hold)    ? hold_q[gi] :
                          (omode == mpc_pkg::mpc_om_instant) ? inst_q[gi] : os_active[gi];

      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          reach_q[gi] <= 1'b0;
          hold_q[gi]  <= 1'b0;
          inst_q[gi]  <= 1'b0;
        end else begin
          reach_q[gi] <= reach[gi] & ~clr_ch[gi];
          inst_q[gi]  <= reach[gi] & ~clr_ch[gi];
          if (clr_ch[gi]) begin
            hold_q[gi] <= 1'b0;
          end else if (done[gi] | restore_out[gi]) begin
            hold_q[gi] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // output routing between the two pins
  wire next_out_a = is_batch ? batch_out : ch_out[0];
  wire next_out_b = (is_two_stage | is_twin | is_batch) ? ch_out[1] : ch_out[0];

  // batch latch
  wire batch_hit = (batch_set != `MPC_VAL_ZERO) && (batch >= batch_set);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pv_a <= `MPC_VAL_ZERO;
      pv_b <= `MPC_VAL_ZERO;
    end else begin
      pv_a <= clr_pv_a ? `MPC_VAL_ZERO : step(pv_a, inc_a, dec_a, lo_a);
      pv_b <= clr_pv_b ? `MPC_VAL_ZERO : step(pv_b, inc_b, 1'b0, `MPC_VAL_ZERO);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      total <= `MPC_VAL_ZERO;
    end else if (clr_total) begin
      total <= `MPC_VAL_ZERO;
    end else begin
      total <= step(total, inc_a & ~rst_a, dec_a & ~rst_a, `MPC_VAL_MIN);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      batch     <= `MPC_VAL_ZERO;
      batch_out <= 1'b0;
    end else if (clr_batch) begin
      batch     <= `MPC_VAL_ZERO;
      batch_out <= 1'b0;
    end else begin
      batch <= step(batch, is_batch & done[0], 1'b0, `MPC_VAL_ZERO);
      if (batch_hit | restore_batch) begin
        batch_out <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ovf <= 1'b0;
    end else if (ovf_hit) begin
      ovf <= 1'b1;
    end else if (op) begin
      ovf <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      control_output_a <= 1'b0;
      control_output_b <= 1'b0;
    end else begin
      control_output_a <= next_out_a;
      control_output_b <= next_out_b;
    end
  end

  // settings
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg        <= `MPC_CFG_RESET;
      set_a      <= `MPC_SET_RESET;
      set_b      <= `MPC_SET_RESET;
      batch_set  <= `MPC_SET_RESET;
      pulse_time <= `MPC_PULSE_RESET;
    end else begin
      if (wr_cfg) begin
        cfg <= reg_wdata[11:0] & `MPC_CFG_MASK;
      end
      if (wr_set_a & set_ok) begin
        set_a <= reg_wdata[23:0];
      end
      if (wr_set_b & set_ok) begin
        set_b <= reg_wdata[23:0];
      end
      if (wr_bset & bset_ok) begin
        batch_set <= reg_wdata[23:0];
      end
      if (wr_ptime & ptime_ok) begin
        pulse_time <= reg_wdata[13:0];
      end
    end
  end

  // read port
  wire [31:0] status = {26'h0000000, os_active[1] | os_active[0], ovf, batch_out,
                        control_output_b, control_output_a, 1'b0};
  wire [31:0] rd_mux =
    (reg_addr == `MPC_ADDR_CONFIG)     ? {20'h00000, cfg} :
    (reg_addr == `MPC_ADDR_SET_A)      ? {{8{set_a[23]}}, set_a} :
    (reg_addr == `MPC_ADDR_SET_B)      ? {{8{set_b[23]}}, set_b} :
    (reg_addr == `MPC_ADDR_BATCH_SET)  ? {8'h00, batch_set} :
    (reg_addr == `MPC_ADDR_PULSE_TIME) ? {18'h00000, pulse_time} :
    (reg_addr == `MPC_ADDR_PV_A)       ? {{8{pv_a[23]}}, pv_a} :
    (reg_addr == `MPC_ADDR_PV_B)       ? {8'h00, pv_b} :
    (reg_addr == `MPC_ADDR_TOTAL)      ? {{8{total[23]}}, total} :
    (reg_addr == `MPC_ADDR_BATCH)      ? {8'h00, batch} :
    (reg_addr == `MPC_ADDR_DUAL)       ? (ovf ? {8'h00, dual_val} : {{8{dual_val[23]}}, dual_val}) :
    (reg_addr == `MPC_ADDR_STATUS)     ? status : 32'h00000000;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
    end
  end
endmodule // mpc_core
`default_nettype wire

// ### verif/mpc_core_chk.sv
`timescale 1ns/1ns
`default_nettype none
module mpc_core_chk #(
  parameter int UNIT_CYC = 10
) (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        reset_input_a,
  input wire logic        reset_input_b,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        control_output_a,
  input wire logic        control_output_b
);
  logic [2:0]  func;
  logic [1:0]  om;
  logic [23:0] bset;
  logic [13:0] pt;
  logic [3:0]  quiet;
  logic [19:0] hi;
  wire         wr_cfg = reg_wr && reg_addr == 4'h0;
  wire         pt_ok  = reg_wdata >= 32'h00000001 && reg_wdata <= 32'h0000270F;
  wire         batch  = func == 3'h3;
  wire         single = func == 3'h0 || func == 3'h2;
  // shadow of configuration seen on the register port
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      func <= 3'h0;
      om   <= 2'h0;
    end else if (wr_cfg) begin
      func <= reg_wdata[2:0];
      om   <= reg_wdata[4:3];
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) bset <= 24'h000000;
    else if (reg_wr && reg_addr == 4'h3 && reg_wdata <= 32'h000F423F) bset <= reg_wdata[23:0];
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) pt <= 14'h0001;
    else if (reg_wr && reg_addr == 4'h4 && pt_ok) pt <= reg_wdata[13:0];
  end
  // cycles since the last config write, command write or cycle with reset_input_b high
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) quiet <= 4'h0;
    else if (wr_cfg || (reg_wr && reg_addr == 4'h5) || reset_input_b) quiet <= 4'h0;
    else if (quiet != 4'hF) quiet <= quiet + 4'h1;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) hi <= 20'h00000;
    else if (control_output_a) hi <= hi + 20'h00001;
    else hi <= 20'h00000;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  a_outs_together: assert property ((single || func == 3'h4) && quiet == 4'hF |-> control_output_a == control_output_b)
    else $error("outputs a and b differ");
  a_reset_clears: assert property ((single && reset_input_a) [*8] |-> !control_output_a)
    else $error("output a on under held primary reset");
  a_oneshot_len: assert property (om == 2'h2 && !batch |-> hi <= pt * UNIT_CYC + 4)
    else $error("one-shot output too long");
  a_batch_latch: assert property (batch && $fell(control_output_a) |-> quiet < 4'h8)
    else $error("batch output dropped without a clear");
  a_batch_hold_off: assert property ((batch && reset_input_b) [*8] |-> !control_output_a)
    else $error("batch output on under batch reset");
  a_batch_zero: assert property (batch && bset == 24'h000000 && !control_output_a |=> !control_output_a)
    else $error("batch output with zero batch set");
  a_twin_b_off: assert property ((func == 3'h5 && reset_input_b) [*8] |-> !control_output_b)
    else $error("twin output b on under its reset");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
    else $error("read data outside read answer");

  c_batch_on: cover property (batch && $rose(control_output_a));
  c_shot_end: cover property (om == 2'h2 && $fell(control_output_a));
  c_twin_b_on: cover property (func == 3'h5 && $rose(control_output_b));
endmodule // mpc_core_chk
bind mpc_core mpc_core_chk #(.UNIT_CYC(UNIT_CYC)) mpc_core_chk_inst (
  .clk(clk), .nrst(nrst), .reset_input_a(reset_input_a), .reset_input_b(reset_input_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .control_output_a(control_output_a), .control_output_b(control_output_b));
`default_nettype wire

// ### verif/mpc_sensor.sv
`timescale 1ns/1ns
`default_nettype none
module mpc_sensor (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [7:0] hi_len,
  output logic            pin,
  output logic            busy
);
  logic [7:0] left;
  initial begin
    pin  = 1'b0;
    busy = 1'b0;
    left = 8'h00;
  end
  // contact closes for hi_len cycles, then rests as long
  always @(posedge clk) begin
    if (go && !busy) begin
      pin  <= 1'b1;
      busy <= 1'b1;
      left <= hi_len;
    end else if (busy && left > 8'h01) begin
      left <= left - 8'h01;
    end else if (busy && pin) begin
      pin  <= 1'b0;
      left <= hi_len;
    end else begin
      busy <= 1'b0;
    end
  end
endmodule // mpc_sensor
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        clk, nrst, ra, rb, wr, rd, rd_q, go_a, go_b;
  logic        pin_a, pin_b, busy_a, busy_b, out_a, out_b;
  logic [3:0]  addr;
  logic [7:0]  len;
  logic [31:0] wdata, rdata, seed;
  logic [31:0] expq[$];
  int          err_total, compares, cycles, na, nb;

  mpc_core #(.SLOW_CYC(20), .FAST_CYC(4), .UNIT_CYC(10)) mpc_core_inst (
    .clk(clk), .nrst(nrst), .count_input_a(pin_a), .count_input_b(pin_b),
    .reset_input_a(ra), .reset_input_b(rb), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .control_output_a(out_a), .control_output_b(out_b));
  mpc_sensor sensor_a (.clk(clk), .go(go_a), .hi_len(len), .pin(pin_a), .busy(busy_a));
  mpc_sensor sensor_b (.clk(clk), .go(go_b), .hi_len(len), .pin(pin_b), .busy(busy_b));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic report_and_stop();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic chk_pin(input logic [1:0] e);
    @(negedge clk);
    chk({30'h0, e}, {30'h0, out_a, out_b});
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    expq.push_back(e);
    @(posedge clk);
    rd   <= 1'b0;
  endtask

  task automatic pulse(input logic b, input int n, input logic [7:0] l);
    repeat (n) begin
      @(posedge clk);
      len <= l;
      if (b) go_b <= 1'b1;
      else go_a <= 1'b1;
      @(posedge clk);
      go_a <= 1'b0;
      go_b <= 1'b0;
      @(posedge clk);
      while (busy_a || busy_b) @(posedge clk);
    end
    repeat (8) @(posedge clk);
  endtask

  task automatic hold(input logic b, input int n);
    @(posedge clk);
    if (b) rb <= 1'b1;
    else ra <= 1'b1;
    repeat (n) @(posedge clk);
    ra <= 1'b0;
    rb <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  // read answers land one cycle after the strobe
  always @(posedge clk) rd_q <= rd;
  always @(negedge clk) begin
    if (rd_q) chk(expq.pop_front(), rdata);
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  initial begin
    nrst = 1'b0; ra = 1'b0; rb = 1'b0; wr = 1'b0; rd = 1'b0; rd_q = 1'b0;
    go_a = 1'b0; go_b = 1'b0; addr = 4'h0; wdata = 32'h0; len = 8'h18;
    seed = 32'h00008AB8; err_total = 0; compares = 0; cycles = 0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(4'h0, 32'h00000000);
    rd_reg(4'h4, 32'h00000001);
    rd_reg(4'hC, 32'h00000000);
    wr_reg(4'h0, 32'h00000100);
    wr_reg(4'h1, 32'hFFFE7961);
    wr_reg(4'h1, 32'hFFFE7960);
    rd_reg(4'h1, 32'hFFFE7961);
    wr_reg(4'h0, 32'h00000000);
    wr_reg(4'h1, 32'h00000003);
    wr_reg(4'h1, 32'h000F4240);
    wr_reg(4'h1, 32'hFFFFFFFF);
    rd_reg(4'h1, 32'h00000003);
    pulse(1'b0, 3, 8'h18);
    chk_pin(2'b11);
    rd_reg(4'h6, 32'h00000003);
    pulse(1'b0, 1, 8'h02);
    rd_reg(4'h6, 32'h00000003);
    @(posedge clk);
    ra <= 1'b1;
    pulse(1'b0, 2, 8'h18);
    ra <= 1'b0;
    repeat (6) @(posedge clk);
    rd_reg(4'h6, 32'h00000000);
    chk_pin(2'b00);
    // total accumulator
    wr_reg(4'h0, 32'h00000802);
    wr_reg(4'h5, 32'h00000001);
    wr_reg(4'h0, 32'h00000002);
    rd_reg(4'h8, 32'h00000000);
    seed = xs(seed);
    na = 1 + int'(seed[0]);
    pulse(1'b0, na, 8'h18);
    hold(1'b0, 10);
    pulse(1'b0, 1, 8'h18);
    rd_reg(4'h6, 32'h00000001);
    rd_reg(4'h8, 32'(na + 1));
    hold(1'b1, 10);
    rd_reg(4'h8, 32'h00000000);
    // one-shot
    wr_reg(4'h0, 32'h00000010);
    wr_reg(4'h4, 32'h00000014);
    wr_reg(4'h4, 32'h00002710);
    rd_reg(4'h4, 32'h00000014);
    wr_reg(4'h5, 32'h00000001);
    pulse(1'b0, 3, 8'h18);
    chk_pin(2'b11);
    hold(1'b0, 10);
    chk_pin(2'b00);
    // batch
    wr_reg(4'h0, 32'h00000003);
    wr_reg(4'h1, 32'h00000001);
    wr_reg(4'h3, 32'h00000002);
    wr_reg(4'h5, 32'h00000001);
    pulse(1'b0, 1, 8'h06);
    rd_reg(4'h9, 32'h00000001);
    hold(1'b0, 10);
    pulse(1'b0, 1, 8'h06);
    rd_reg(4'h9, 32'h00000002);
    chk_pin(2'b11);
    wr_reg(4'h3, 32'h00000005);
    chk_pin(2'b11);
    hold(1'b1, 10);
    rd_reg(4'h9, 32'h00000000);
    chk_pin(2'b01);
    // dual
    wr_reg(4'h0, 32'h00000044);
    wr_reg(4'h5, 32'h00000001);
    seed = xs(seed);
    na = 2 + int'(seed[0]);
    nb = 1 + int'(seed[1]);
    pulse(1'b0, na, 8'h18);
    pulse(1'b1, nb, 8'h18);
    rd_reg(4'hA, 32'(na + nb));
    wr_reg(4'h0, 32'h00000244);
    rd_reg(4'hA, 32'(na - nb));
    @(posedge clk);
    rb <= 1'b1;
    repeat (8) @(posedge clk);
    rd_reg(4'hA, 32'(na));
    rb <= 1'b0;
    repeat (6) @(posedge clk);
    // twin
    wr_reg(4'h0, 32'h00000005);
    wr_reg(4'h2, 32'h00000001);
    wr_reg(4'h5, 32'h00000001);
    hold(1'b1, 10);
    chk_pin(2'b00);
    pulse(1'b1, 1, 8'h18);
    chk_pin(2'b01);
    hold(1'b1, 10);
    chk_pin(2'b00);
    // restored outputs, then signed down count below zero
    wr_reg(4'h0, 32'h00000400);
    wr_reg(4'h5, 32'h0000000E);
    @(posedge clk);
    chk_pin(2'b11);
    wr_reg(4'h0, 32'h00000120);
    pulse(1'b0, 1, 8'h18);
    rd_reg(4'h6, 32'hFFFFFFFF);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
